// ---- adp_params.svh ----
/*
  Constants for the card-side data transfer port: PIO wait, Multiword DMA
  request, Ultra DMA bursts. Assumes inclusion by bare name.
*/
`ifndef ADP_PARAMS_SVH
`define ADP_PARAMS_SVH
`define ADP_CLK_NS        25
`define ADP_RD_LEAD_NS    25
`define ADP_RD_LEAD_CYC   ((`ADP_RD_LEAD_NS + `ADP_CLK_NS - 1) / `ADP_CLK_NS)
`define ADP_SETTLE_NS     75
`define ADP_SETTLE_CYC    ((`ADP_SETTLE_NS + `ADP_CLK_NS - 1) / `ADP_CLK_NS)
`define ADP_FIFO_DEPTH    32
`define ADP_CRC_INIT      16'h4aba
`define ADP_CRC_POLY      16'h1021
`define ADP_ADDR_LOW_BITS 3
`define ADP_MODE_MEM      2'h0
`define ADP_MODE_IO       2'h1
`define ADP_MODE_IDE      2'h2
`endif

// ---- adp_pkg.sv ----
/*
  Types shared by the transfer port modules. Assumes adp_params.svh constants.
*/
package adp_pkg;
  typedef struct packed {
    logic       ce1_b;
    logic       ce2_b;
    logic [2:0] addr;
  } adp_dev_addr_t;

  typedef struct packed {
    logic        rd_strobe;
    logic        wr_strobe;
    logic        reg_sel;
    logic [10:0] addr;
    logic        ce1_b;
    logic        ce2_b;
  } adp_host_pins_t;

  typedef enum logic [6:0] {
    ADP_IDLE    = 7'h01,
    ADP_PIO     = 7'h02,
    ADP_MDMA    = 7'h04,
    ADP_U_IN    = 7'h08,
    ADP_U_OUT   = 7'h10,
    ADP_U_CRC   = 7'h20,
    ADP_PAUSE   = 7'h40
  } adp_state_t;
endpackage

// ---- adp_fifo.sv ----
/*
  Word FIFO with valid/ready on both sides. Assumes one clock, async low reset.
*/
`timescale 1ns/10ps
module adp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop, in_ready_reg, out_valid_reg;
  logic [WIDTH-1:0] out_data_reg, out_data_next;

  always_comb begin
    push     = in_valid && in_ready_reg;
    pop      = out_ready && out_valid_reg;
    wp_next  = push ? wp_reg + 1'b1 : wp_reg;
    rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Head word registered; a word written into the head slot bypasses memory
    out_data_next = (push && (wp_reg == rp_next)) ? in_data : mem[rp_next];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg        <= '0;
      rp_reg        <= '0;
      cnt_reg       <= '0;
      in_ready_reg  <= 1'b1;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else begin
      wp_reg        <= wp_next;
      rp_reg        <= rp_next;
      cnt_reg       <= cnt_next;
      in_ready_reg  <= (cnt_next != (AW+1)'(DEPTH));
      out_valid_reg <= (cnt_next != '0);
      out_data_reg  <= out_data_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  assign in_ready  = in_ready_reg;
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;
endmodule // adp_fifo

// ---- adp_crc.sv ----
/*
  Burst CRC accumulator, one 16-bit word per step. Assumes same clock as user.
*/
`timescale 1ns/10ps
`include "adp_params.svh"
module adp_crc (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Control and data
  input  wire logic        clear,
  input  wire logic        step,
  input  wire logic [15:0] word,
  output logic [15:0]      crc
);
  logic [15:0] crc_reg, crc_next;

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ `ADP_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    crc_next = crc_reg;
    if (clear) begin
      crc_next = `ADP_CRC_INIT;
    end else if (step) begin
      crc_next = crc_word(crc_reg, word);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crc_reg <= `ADP_CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc = crc_reg;
endmodule // adp_crc

// ---- adp_port.sv ----
/*
  Card-side data transfer port: PIO wait insertion, Multiword DMA request,
  Ultra DMA bursts with double-edge strobes and CRC check on data-out bursts. Assumes host pins
  are asynchronous to clk; card core supplies/consumes words on user ports.
*/
`timescale 1ns/10ps
`include "adp_params.svh"
module adp_port #(
  parameter int DEPTH = `ADP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Host control pins
  input  wire adp_pkg::adp_host_pins_t host_pins,
  input  wire logic                 cable_select_in,
  // Host data bus, three-signal form
  input  wire logic [15:0]          host_data_in,
  output logic [15:0]               host_data_out,
  output logic [15:0]               host_data_oe,
  // Device outputs
  output logic                      iordy_out,
  output logic                      dmarq_out,
  output logic                      host_interrupt_out,
  output logic                      iocs16_b,
  // Core configuration
  input  wire logic [1:0]           if_mode,
  input  wire logic                 udma_sel_req,
  input  wire logic                 udma_sel_valid,
  input  wire logic                 dma_cmd,
  input  wire logic                 dma_dir_in,
  input  wire logic                 byte_wide,
  input  wire logic                 core_busy,
  // Core data
  input  wire logic                 tx_valid,
  output logic                      tx_ready,
  input  wire logic [15:0]          tx_data,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output logic [15:0]               rx_data,
  // Status
  output logic                      crc_error,
  output adp_pkg::adp_dev_addr_t    dev_addr,
  output logic                      burst_active
);
  import adp_pkg::*;

  // Input synchronisers
  adp_host_pins_t hp_s1, hp_s2;
  logic [15:0]    hd_s1, hd_s2;
  logic           cs_s1, cs_s2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hp_s1 <= '{1'b1, 1'b1, 1'b1, 11'h000, 1'b1, 1'b1};
      hp_s2 <= '{1'b1, 1'b1, 1'b1, 11'h000, 1'b1, 1'b1};
      hd_s1 <= 16'h0000;
      hd_s2 <= 16'h0000;
      cs_s1 <= 1'b0;
      cs_s2 <= 1'b0;
    end else begin
      hp_s1 <= host_pins;
      hp_s2 <= hp_s1;
      hd_s1 <= host_data_in;
      hd_s2 <= hd_s1;
      cs_s1 <= cable_select_in;
      cs_s2 <= cs_s1;
    end
  end

  // Pin meanings; strobe and select pins are active low
  logic rd_act, wr_act, dmack, stop, hstrobe, hdmardy, sel;
  always_comb begin
    rd_act  = !hp_s2.rd_strobe;
    wr_act  = !hp_s2.wr_strobe;
    dmack   = !hp_s2.reg_sel;
    stop    = wr_act;
    hstrobe = hp_s2.rd_strobe;
    hdmardy = !hp_s2.rd_strobe;
    sel     = !hp_s2.ce1_b || !hp_s2.ce2_b;
  end

  // FIFOs and CRC
  logic        rxf_in_valid, rxf_in_ready, txf_out_ready, txf_out_valid;
  logic [15:0] rxf_in_data, txf_out_data, crc_val;
  logic        crc_clear, crc_step;
  logic [15:0] crc_word_in;

  adp_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_rx_fifo (
    .clk(clk), .rst_b(rst_b),
    .in_valid(rxf_in_valid), .in_ready(rxf_in_ready), .in_data(rxf_in_data),
    .out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
  );
  adp_fifo #(.WIDTH(16), .DEPTH(DEPTH)) u_tx_fifo (
    .clk(clk), .rst_b(rst_b),
    .in_valid(tx_valid), .in_ready(tx_ready), .in_data(tx_data),
    .out_valid(txf_out_valid), .out_ready(txf_out_ready), .out_data(txf_out_data)
  );
  adp_crc u_crc (
    .clk(clk), .rst_b(rst_b), .clear(crc_clear), .step(crc_step),
    .word(crc_word_in), .crc(crc_val)
  );

  // Main state
  adp_state_t  st_reg, st_next;
  logic        udma_en_reg, udma_en_next;
  logic        iordy_reg, iordy_next;
  logic        dmarq_reg, dmarq_next;
  logic        intr_reg, intr_next;
  logic        crcerr_reg, crcerr_next;
  logic        strb_reg, strb_next;
  logic        hs_last_reg, hs_last_next;
  logic        rd_last_reg, rd_last_next;
  logic [15:0] dout_reg, dout_next;
  logic [15:0] doe_reg, doe_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic        rd_pend_reg, rd_pend_next;
  logic        iocs_reg, iocs_next;
  adp_dev_addr_t addr_reg, addr_next;

  always_comb begin
    st_next      = st_reg;
    udma_en_next = udma_en_reg;
    iordy_next   = iordy_reg;
    dmarq_next   = dmarq_reg;
    intr_next    = intr_reg;
    crcerr_next  = crcerr_reg;
    strb_next    = strb_reg;
    hs_last_next = hstrobe;
    rd_last_next = rd_act;
    dout_next    = dout_reg;
    doe_next     = doe_reg;
    cnt_next     = cnt_reg;
    rd_pend_next = rd_pend_reg;
    rxf_in_valid = 1'b0;
    rxf_in_data  = hd_s2;
    txf_out_ready = 1'b0;
    crc_clear    = 1'b0;
    crc_step     = 1'b0;
    crc_word_in  = hd_s2;
    // Low three address bits only; lines 3..10 ignored
    addr_next    = '{hp_s2.ce1_b, hp_s2.ce2_b, hp_s2.addr[`ADP_ADDR_LOW_BITS-1:0]};
    iocs_next    = !(sel && !byte_wide);
    if (udma_sel_valid) begin
      udma_en_next = udma_sel_req;
    end
    // Clear first so a burst end in the same cycle still raises the interrupt
    if (!dma_cmd) begin
      intr_next = 1'b0;
    end
    unique case (st_reg)
      ADP_IDLE: begin
        doe_next   = 16'h0000;
        iordy_next = 1'b1;
        strb_next  = 1'b1;
        if (dma_cmd && (dma_dir_in ? txf_out_valid : rxf_in_ready)) begin
          dmarq_next = 1'b1;
        end else begin
          dmarq_next = 1'b0;
        end
        if (dmarq_reg && dmack && udma_en_reg && dma_cmd) begin
          crc_clear = 1'b1;
          cnt_next  = 2'(`ADP_SETTLE_CYC);
          st_next   = dma_dir_in ? ADP_U_IN : ADP_U_OUT;
        end else if (dmarq_reg && dmack && dma_cmd) begin
          st_next = ADP_MDMA;
        end else if (sel && (rd_act || wr_act)) begin
          if (core_busy) begin
            iordy_next = 1'b0;
          end
          rd_pend_next = rd_act;
          st_next      = ADP_PIO;
        end
      end
      ADP_PIO: begin
        if (rd_pend_reg) begin
          doe_next  = byte_wide ? 16'h00ff : 16'hffff;
          dout_next = txf_out_data;
        end
        if (iordy_reg == 1'b0) begin
          if (!core_busy) begin
            // Data placed first, IORDY raised after the lead time
            if (cnt_reg == 2'(`ADP_RD_LEAD_CYC)) begin
              iordy_next = 1'b1;
              cnt_next   = 2'h0;
            end else begin
              cnt_next = cnt_reg + 2'h1;
            end
          end
        end else if (!rd_act && !wr_act) begin
          if (rd_pend_reg) begin
            txf_out_ready = 1'b1;
          end else begin
            rxf_in_valid = 1'b1;
          end
          doe_next = 16'h0000;
          st_next  = ADP_IDLE;
        end
      end
      ADP_MDMA: begin
        if (!dmack) begin
          st_next = ADP_IDLE;
        end else if (dma_dir_in) begin
          dout_next = txf_out_data;
          doe_next  = 16'hffff;
          if (rd_last_reg && !rd_act) begin
            txf_out_ready = 1'b1;
          end
          dmarq_next = txf_out_valid;
        end else begin
          doe_next = 16'h0000;
          if (wr_act && !rd_last_reg && rxf_in_ready) begin
            rxf_in_valid = 1'b1;
          end
          rd_last_next = wr_act;
          dmarq_next   = rxf_in_ready;
        end
      end
      ADP_U_IN: begin
        doe_next = 16'hffff;
        if (!dmack) begin
          st_next = ADP_IDLE;
        end else if (stop) begin
          dmarq_next = 1'b0;
          st_next    = ADP_PAUSE;
        end else if (cnt_reg != 2'h0) begin
          cnt_next = cnt_reg - 2'h1;
        end else if (hdmardy && txf_out_valid) begin
          // Word on the bus, then the strobe flips after settling
          if (dout_reg == txf_out_data && doe_reg == 16'hffff) begin
            strb_next     = !strb_reg;
            txf_out_ready = 1'b1;
            crc_step      = 1'b1;
            crc_word_in   = txf_out_data;
            cnt_next      = 2'(`ADP_SETTLE_CYC);
          end
          dout_next = txf_out_data;
        end
      end
      ADP_U_OUT: begin
        doe_next   = 16'h0000;
        iordy_next = !rxf_in_ready;
        if (!dmack) begin
          st_next = ADP_IDLE;
        end else if (stop) begin
          dmarq_next = 1'b0;
          st_next    = ADP_U_CRC;
        end else if (hstrobe != hs_last_reg) begin
          rxf_in_valid = 1'b1;
          crc_step     = 1'b1;
        end
      end
      ADP_U_CRC: begin
        if (!dmack) begin
          crcerr_next = crcerr_reg || (hd_s2 != crc_val);
          intr_next   = 1'b1;
          st_next     = ADP_IDLE;
        end
      end
      ADP_PAUSE: begin
        if (!dmack) begin
          doe_next  = 16'h0000;
          intr_next = 1'b1;
          st_next   = ADP_IDLE;
        end
      end
      default: st_next = ADP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg      <= ADP_IDLE;
      udma_en_reg <= 1'b0;
      iordy_reg   <= 1'b1;
      dmarq_reg   <= 1'b0;
      intr_reg    <= 1'b0;
      crcerr_reg  <= 1'b0;
      strb_reg    <= 1'b1;
      hs_last_reg <= 1'b1;
      rd_last_reg <= 1'b0;
      dout_reg    <= 16'h0000;
      doe_reg     <= 16'h0000;
      cnt_reg     <= 2'h0;
      rd_pend_reg <= 1'b0;
      iocs_reg    <= 1'b1;
      addr_reg    <= '{1'b1, 1'b1, 3'h0};
    end else begin
      st_reg      <= st_next;
      udma_en_reg <= udma_en_next;
      iordy_reg   <= iordy_next;
      dmarq_reg   <= dmarq_next;
      intr_reg    <= intr_next;
      crcerr_reg  <= crcerr_next;
      strb_reg    <= strb_next;
      hs_last_reg <= hs_last_next;
      rd_last_reg <= rd_last_next;
      dout_reg    <= dout_next;
      doe_reg     <= doe_next;
      cnt_reg     <= cnt_next;
      rd_pend_reg <= rd_pend_next;
      iocs_reg    <= iocs_next;
      addr_reg    <= addr_next;
    end
  end

  // IORDY pin carries DSTROBE during a data-in burst
  logic iordy_pin_reg, burst_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      iordy_pin_reg <= 1'b1;
      burst_reg     <= 1'b0;
    end else begin
      iordy_pin_reg <= (st_next == ADP_U_IN) ? strb_next : iordy_next;
      burst_reg     <= (st_next == ADP_U_IN) || (st_next == ADP_U_OUT) ||
                       (st_next == ADP_U_CRC) || (st_next == ADP_PAUSE);
    end
  end

  assign host_data_out      = dout_reg;
  assign host_data_oe       = doe_reg;
  assign iordy_out          = iordy_pin_reg;
  assign dmarq_out          = dmarq_reg;
  assign host_interrupt_out = intr_reg;
  assign iocs16_b           = iocs_reg;
  assign crc_error          = crcerr_reg;
  assign dev_addr           = addr_reg;
  assign burst_active       = burst_reg;
endmodule // adp_port

// ---- adp_port_props.sv ----
/*
  Pin-level checks for the card transfer port.
  Assumes a bind onto adp_port in the bench top file.
*/
`timescale 1ns/10ps
module adp_port_props (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // Watched ports
  input wire adp_pkg::adp_host_pins_t host_pins,
  input wire logic [15:0]            host_data_oe,
  input wire logic                   iordy_out,
  input wire logic                   dmarq_out,
  input wire logic                   iocs16_b,
  input wire logic                   byte_wide,
  input wire logic                   core_busy,
  input wire logic                   dma_cmd,
  input wire logic                   dma_dir_in,
  input wire logic                   crc_error,
  input wire adp_pkg::adp_dev_addr_t dev_addr,
  input wire logic                   burst_active
);
  import adp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  dev_addr_map_a: assert property (
    ($stable(host_pins.addr) && $stable(host_pins.ce1_b) && $stable(host_pins.ce2_b))[*5]
    |-> dev_addr == {host_pins.ce1_b, host_pins.ce2_b, host_pins.addr[2:0]})
    else $error("dev_addr does not follow enables and low address");
  byte_sel_a: assert property (
    byte_wide[*4] |-> iocs16_b) else $error("16-bit select low while byte wide");
  wait_insert_a: assert property (
    $fell(host_pins.rd_strobe) && core_busy && !burst_active ##1 core_busy[*4]
    |-> ##[0:3] !iordy_out) else $error("no wait while core busy");
  no_wait_a: assert property (
    (!core_busy && !burst_active)[*6] |-> iordy_out) else $error("wait without busy core");
  read_lead_a: assert property (
    $rose(iordy_out) && !burst_active && !$past(burst_active) && !host_pins.rd_strobe
    |-> $past(host_data_oe) != 16'h0000) else $error("iordy rose before read data");
  burst_entry_a: assert property (
    $rose(burst_active) |-> dma_cmd && $past(dmarq_out) && !host_pins.reg_sel)
    else $error("burst entered without its conditions");
  burst_exit_a: assert property (
    host_pins.reg_sel[*6] |-> !burst_active) else $error("burst kept after DMACK drop");
  out_owner_a: assert property (
    burst_active && !dma_dir_in |-> host_data_oe == 16'h0000)
    else $error("device drove bus in data-out burst");
  strobe_space_a: assert property (
    burst_active && dma_dir_in && $changed(iordy_out)
    |-> host_data_oe != 16'h0000 ##1 $stable(iordy_out)[*3])
    else $error("DSTROBE undriven data or too fast");
  crc_sticky_a: assert property (
    crc_error |=> crc_error) else $error("crc_error not sticky");
endmodule // adp_port_props

// ---- adp_host_model.sv ----
/*
  Behavioural host controller for PIO reads and Ultra DMA bursts.
  Assumes the bench calls its tasks; data-out HSTROBE edges run at a 200 ns link period, Multiword DMA cycles at 600 ns.
*/
`timescale 1ns/10ps
module adp_host_model (
  // Clock for bus snapshots
  input wire logic                 clk,
  // Host driven pins
  output adp_pkg::adp_host_pins_t  host_pins,
  output logic [15:0]              host_data_in,
  // Device driven pins
  input wire logic [15:0]          host_data_out,
  input wire logic [15:0]          host_data_oe,
  input wire logic                 iordy_out,
  input wire logic                 dmarq_out
);
  import adp_pkg::*;
  logic [15:0] drv_val, last_val, d_prev;
  logic        drv_en, cap_en;
  logic [15:0] cap_q[$];

  initial begin
    host_pins = '{1'b1, 1'b1, 1'b1, 11'h000, 1'b1, 1'b1};
    drv_en = 1'b0;
    drv_val = 16'h0000;
    last_val = 16'h0000;
    cap_en = 1'b0;
  end
  // Released bus shows a pattern that flips every cycle
  always_comb host_data_in = (host_data_oe & host_data_out)
                           | (~host_data_oe & (drv_en ? drv_val : ~last_val));
  always @(posedge clk) last_val <= host_data_in;
  always @(negedge clk) d_prev <= host_data_out;
  // Word latched on each DSTROBE edge, taken before the edge's own cycle
  always @(iordy_out) if (cap_en) cap_q.push_back(d_prev);

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int b = 15; b >= 0; b--) r = {r[14:0], 1'b0} ^ ((r[15] ^ w[b]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction

  task automatic wait_rq();
    for (int k = 0; k < 100 && !dmarq_out; k++) #25;
  endtask

  // Sample point well after strobe, then hold strobe until IORDY returns
  task automatic pio_read(input logic [10:0] addr, output logic waited);
    host_pins.ce1_b = 1'b0;
    host_pins.addr = addr;
    #103;
    host_pins.rd_strobe = 1'b0;
    #100;
    waited = !iordy_out;
    for (int k = 0; k < 400 && !iordy_out; k++) #25;
    #100;
    host_pins.rd_strobe = 1'b1;
    #100;
    host_pins.ce1_b = 1'b1;
  endtask

  // Multiword DMA write with a stretched strobe; each cycle lasts 600 ns
  task automatic mdma_out(input int n, input logic [15:0] base);
    wait_rq();
    #3 host_pins.reg_sel = 1'b0;
    drv_en = 1'b1;
    for (int i = 0; i < n; i++) begin
      drv_val = base + 16'(i);
      #100 host_pins.wr_strobe = 1'b0;
      #250 host_pins.wr_strobe = 1'b1;
      #250;
    end
    host_pins.reg_sel = 1'b1;
    drv_en = 1'b0;
  endtask

  // Data-out: reg_sel is DMACK, rd_strobe HSTROBE, wr_strobe STOP
  task automatic udma_out(input int n, input logic [15:0] base, input logic bad);
    logic [15:0] crc;
    crc = 16'h4aba;
    wait_rq();
    #3 host_pins.reg_sel = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 200 && iordy_out; k++) #25;
      drv_en = 1'b1;
      drv_val = base + 16'(i);
      crc = crc_step(crc, drv_val);
      #100;
      host_pins.rd_strobe = ~host_pins.rd_strobe;
      #100;
    end
    host_pins.wr_strobe = 1'b0;
    #200;
    drv_val = bad ? ~crc : crc;
    #200;
    host_pins.reg_sel = 1'b1;
    #100;
    drv_en = 1'b0;
    host_pins.wr_strobe = 1'b1;
    host_pins.rd_strobe = 1'b1;
  endtask

  // Data-in: rd_strobe is HDMARDY, pulled high once at stall to pause
  task automatic udma_in(input int n, input int stall);
    cap_q.delete();
    wait_rq();
    #3 host_pins.reg_sel = 1'b0;
    #200;
    cap_en = 1'b1;
    host_pins.rd_strobe = 1'b0;
    for (int k = 0; k < 2000 && cap_q.size() < n; k++) begin
      #25;
      if (k == stall) begin
        host_pins.rd_strobe = 1'b1;
        #400 host_pins.rd_strobe = 1'b0;
      end
    end
    host_pins.wr_strobe = 1'b0;
    #300 cap_en = 1'b0;
    host_pins.reg_sel = 1'b1;
    #100 host_pins.wr_strobe = 1'b1;
    host_pins.rd_strobe = 1'b1;
  endtask
endmodule // adp_host_model

// ---- adp_port_bench.sv ----
/*
  Self-checking bench for adp_port with a host model.
  Assumes a 40 MHz clock and the host model's task interface.
*/
`timescale 1ns/10ps
module adp_port_bench;
  import adp_pkg::*;
  logic clk, rst_b, cable_select_in, udma_sel_req, udma_sel_valid;
  logic dma_cmd, dma_dir_in, byte_wide, core_busy, tx_valid, rx_ready;
  logic tx_ready, rx_valid, iordy_out, dmarq_out, host_interrupt_out, iocs16_b;
  logic crc_error, burst_active;
  logic [1:0] if_mode;
  logic [15:0] host_data_in, host_data_out, host_data_oe, tx_data, rx_data;
  adp_host_pins_t host_pins;
  adp_dev_addr_t dev_addr;
  int err_count, num_checks;
  logic [15:0] rx_q[$];

  adp_port #(.DEPTH(32)) u_dut (.clk, .rst_b, .host_pins, .cable_select_in, .host_data_in,
    .host_data_out, .host_data_oe, .iordy_out, .dmarq_out, .host_interrupt_out, .iocs16_b,
    .if_mode, .udma_sel_req, .udma_sel_valid, .dma_cmd, .dma_dir_in, .byte_wide, .core_busy,
    .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data, .crc_error, .dev_addr,
    .burst_active);
  adp_host_model u_host (.clk, .host_pins, .host_data_in, .host_data_out, .host_data_oe,
    .iordy_out, .dmarq_out);

  always #12.5 clk = ~clk;
  always @(negedge clk) if (rx_valid === 1'b1 && rx_ready === 1'b1) rx_q.push_back(rx_data);

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset();
    @(negedge clk) rst_b = 1'b0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic udma_enable();
    @(negedge clk) udma_sel_req = 1'b1;
    udma_sel_valid = 1'b1;
    @(negedge clk) udma_sel_valid = 1'b0;
  endtask

  task automatic no_burst();
    dma_cmd = 1'b1;
    u_host.host_pins.reg_sel = 1'b0;
    repeat (20) @(negedge clk);
    check("burst_active", burst_active, 1'b0);
    u_host.host_pins.reg_sel = 1'b1;
    dma_cmd = 1'b0;
    repeat (8) @(negedge clk);
  endtask

  task automatic t_reset();
    check("iordy_out", iordy_out, 1'b1);
    check("dmarq_out", dmarq_out, 1'b0);
    check("host_data_oe", host_data_oe, 16'h0000);
    check("crc_error", crc_error, 1'b0);
    check("iocs16_b", iocs16_b, 1'b1);
    check("host_interrupt_out", host_interrupt_out, 1'b0);
    no_burst();
    $display("test reset done");
  endtask

  task automatic t_pio();
    logic w;
    core_busy = 1'b1;
    fork
      u_host.pio_read(11'h7fd, w);
      begin
        repeat (12) @(negedge clk);
        check("iordy_out", iordy_out, 1'b0);
        check("dev_addr", dev_addr, 16'h000d);
        check("iocs16_b", iocs16_b, 1'b0);
        core_busy = 1'b0;
      end
    join
    check("waited", w, 1'b1);
    byte_wide = 1'b1;
    repeat (8) @(negedge clk);
    check("iocs16_b", iocs16_b, 1'b1);
    byte_wide = 1'b0;
    $display("test pio done");
  endtask

  task automatic t_fill();
    int n;
    n = 0;
    tx_valid = 1'b1;
    repeat (40) begin
      tx_data = 16'h0100 + 16'(n);
      if (tx_ready === 1'b1) n++;
      @(negedge clk);
    end
    tx_valid = 1'b0;
    check("fifo_count", 16'(n), 16'h0020);
    $display("test fill done");
  endtask

  task automatic t_udma_in();
    udma_enable();
    dma_dir_in = 1'b1;
    dma_cmd = 1'b1;
    u_host.udma_in(32, 40);
    check("in_count", 16'(u_host.cap_q.size()), 16'h0020);
    foreach (u_host.cap_q[i]) check("in_word", u_host.cap_q[i], 16'h0100 + 16'(i));
    check("tx_ready", tx_ready, 1'b1);
    dma_cmd = 1'b0;
    dma_dir_in = 1'b0;
    repeat (8) @(negedge clk);
    $display("test udma in done");
  endtask

  task automatic t_udma_out();
    for (int m = 0; m < 3; m++) begin
      if_mode = 2'(m);
      rx_q.delete();
      dma_cmd = 1'b1;
      u_host.udma_out(3, 16'ha000 + 16'(m * 16), 1'b0);
      repeat (8) @(negedge clk);
      check("out_count", 16'(rx_q.size()), 16'h0003);
      foreach (rx_q[i]) check("out_word", rx_q[i], 16'ha000 + 16'(m * 16 + i));
      check("crc_error", crc_error, 1'b0);
      check("burst_active", burst_active, 1'b0);
      check("host_interrupt_out", host_interrupt_out, 1'b1);
      dma_cmd = 1'b0;
      repeat (4) @(negedge clk);
      check("host_interrupt_out", host_interrupt_out, 1'b0);
    end
    $display("test udma out done");
  endtask

  task automatic t_crc_bad();
    dma_cmd = 1'b1;
    u_host.udma_out(2, 16'h5a5a, 1'b1);
    repeat (8) @(negedge clk);
    check("crc_error", crc_error, 1'b1);
    dma_cmd = 1'b0;
    do_reset();
    check("crc_error", crc_error, 1'b0);
    no_burst();
    $display("test crc done");
  endtask

  task automatic t_mdma();
    rx_q.delete();
    dma_cmd = 1'b1;
    u_host.mdma_out(3, 16'h3c00);
    repeat (8) @(negedge clk);
    check("mdma_count", 16'(rx_q.size()), 16'h0003);
    foreach (rx_q[i]) check("mdma_word", rx_q[i], 16'h3c00 + 16'(i));
    check("dmarq_out", dmarq_out, 1'b1);
    dma_cmd = 1'b0;
    repeat (4) @(negedge clk);
    check("dmarq_out", dmarq_out, 1'b0);
    $display("test mdma done");
  endtask

  initial begin
    {clk, rst_b, cable_select_in, udma_sel_req, udma_sel_valid} = 5'h00;
    {dma_cmd, dma_dir_in, byte_wide, core_busy, tx_valid} = 5'h00;
    rx_ready = 1'b1;
    if_mode = 2'h2;
    tx_data = 16'h0000;
    err_count = 0;
    num_checks = 0;
    do_reset();
    t_reset();
    t_pio();
    t_fill();
    t_udma_in();
    t_udma_out();
    t_crc_bad();
    t_mdma();
    conclude();
  end

  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule // adp_port_bench

bind adp_port adp_port_props u_props (.clk, .rst_b, .host_pins, .host_data_oe, .iordy_out,
  .dmarq_out, .iocs16_b, .byte_wide, .core_busy, .dma_cmd, .dma_dir_in, .crc_error, .dev_addr,
  .burst_active);
